// ---- fault_resp_consts.svh ----
`ifndef FAULT_RESP_CONSTS_SVH
`define FAULT_RESP_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define FR_ADDR_W 5
`define FR_REG_CONFIG 5'h00
`define FR_REG_THRESH 5'h04
`define FR_REG_TIMING 5'h08
`define FR_REG_STATUS 5'h0C
`define FR_REG_CONTROL 5'h10

// ------------------------------------------------------------
// config, threshold, timing and control register fields
// ------------------------------------------------------------
`define FR_CFG_CYC_MODE_LSB 0
`define FR_CFG_STALL_MODE_LSB 4
`define FR_CFG_WARN_REP_BIT 8
`define FR_CFG_CYC_RETRY_LSB 12
`define FR_THR_CLOSED_LSB 0
`define FR_THR_OPEN_LSB 8
`define FR_TIM_FILTER_LSB 0
`define FR_TIM_RETRY_LSB 16
`define FR_CTL_CLEAR_BIT 0

// ------------------------------------------------------------
// status register bits
// ------------------------------------------------------------
`define FR_ST_CTRL_FAULT 0
`define FR_ST_DRV_FAULT 1
`define FR_ST_CYC_FLAG 2
`define FR_ST_STALL_FLAG 3
`define FR_ST_OVERTEMP 4
`define FR_ST_WARN_FLAG 5
`define FR_ST_SHUT_FLAG 6
`define FR_ST_PIN_LEVEL 7

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define FR_CONFIG_RST 32'h0000_0000
`define FR_THRESH_RST 32'h0000_8080
`define FR_TIMING_RST 32'h03E8_0064

// ------------------------------------------------------------
// timing: retry time unit is one microsecond tick
// ------------------------------------------------------------
`define FR_CLK_PERIOD_NS 25
`define FR_TICK_NS 1000
`define FR_TICK_CYCLES (`FR_TICK_NS / `FR_CLK_PERIOD_NS)

`endif

// ---- fault_resp_pkg.sv ----
package fault_resp_pkg;

  // cycle-limit response state, one-hot
  typedef enum logic [2:0] {
    CYC_IDLE = 3'b001,
    CYC_LIMIT = 3'b010,
    CYC_REPORT = 3'b100
  } cyc_state_t;

  // stall-current response state, one-hot
  typedef enum logic [3:0] {
    STALL_IDLE = 4'b0001,
    STALL_LATCH = 4'b0010,
    STALL_RETRY = 4'b0100,
    STALL_REPORT = 4'b1000
  } stall_state_t;

  // requested output-stage condition for the gate drivers
  typedef enum logic [2:0] {
    STAGE_NORMAL = 3'h0,
    STAGE_RECIRC = 3'h1,
    STAGE_ALL_OFF = 3'h2,
    STAGE_SWITCH_OFF = 3'h3,
    STAGE_HIGH_ON = 3'h4,
    STAGE_LOW_ON = 3'h5
  } stage_t;

endpackage : fault_resp_pkg

// ---- fault_resp.sv ----
`timescale 1ns/100ps
`include "fault_resp_consts.svh"
// Notes on behaviour
// (R1) comparator trip starts cycle-limit response per mode
// (R2) threshold: closed-loop setting or open-loop cap
// (R3) 000x: recirculate, flag, resume next PWM
// (R4) 0000 asserts fault and pin; 0001 neither
// (R5) 001x: resume when sense drops; 0010 reports
// (R6) 010x: resume after retry+1 PWM; 0100 reports
// (R7) 0110: report only, clear needs command
// (R8) 0111 or 1xxx: cycle limit ignored
// (R9) stall event after filter time exceeded
// (R10) low mode bits pick stage; pin low
// (R11) 00xx latched until gone and cleared
// (R12) 01xx auto resume after retry time
// (R13) 1000 report only, clear needs command
// (R14) 1xx1: stall current ignored
// (R15) warning: pin low, flags, release at hysteresis
// (R16) warning flag held until cleared and cool
// (R17) shutdown: all off, pump off, auto resume
// (R18) shutdown flag latched; never disabled
// (R19) host writes one to clear bit
// (R20) analog indications synchronised before use
// (R21) restart filter and retry timers
module fault_resp #(
  parameter int FILTER_W = 16,
  parameter int RETRY_W = 16
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // avalon-mm slave
  input wire logic [`FR_ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // analog indications, asynchronous
  input wire logic CYC_TRIP_IN,
  input wire logic STALL_OVER_IN,
  input wire logic TEMP_WARN_IN,
  input wire logic TEMP_WARN_HYS_IN,
  input wire logic TEMP_SHUT_IN,
  input wire logic TEMP_SHUT_HYS_IN,
  // motor control context, same clock
  input wire logic PWM_START_IN,
  input wire logic LOOP_CLOSED_IN,
  // open-drain fault pin
  input wire logic FAULT_PIN_N_IN,
  output logic FAULT_PIN_N_OUT,
  output logic FAULT_PIN_N_OE_OUT,
  // output stage control
  output logic [2:0] GATE_STAGE_OUT,
  output logic CHARGE_PUMP_EN_OUT,
  output logic [7:0] CYC_THRESHOLD_OUT
);

  // ------------------------------------------------------------
  // reset release and input synchronisers
  // ------------------------------------------------------------
  logic rst_s1; // first reset stage
  logic rst_n; // released reset
  logic [6:0] sync1; // first stage, read only by sync2
  logic [6:0] sync2; // synchronised copies
  logic trip; // sense above cycle limit
  logic over; // sampled sense above stall threshold
  logic warn; // above warning limit
  logic warn_hys; // above warning release point
  logic shut; // above shutdown limit
  logic shut_hys; // above shutdown release point
  logic pin_level; // level seen on the fault pin

  // async assert, two-flop release
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // two flops on every analog flag
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
    end else begin
      sync1 <= {FAULT_PIN_N_IN, TEMP_SHUT_HYS_IN, TEMP_SHUT_IN,
                TEMP_WARN_HYS_IN, TEMP_WARN_IN, STALL_OVER_IN,
                CYC_TRIP_IN}; // see (R20)
      sync2 <= sync1;
    end
  end

  assign trip = sync2[0];
  assign over = sync2[1];
  assign warn = sync2[2];
  assign warn_hys = sync2[3];
  assign shut = sync2[4];
  assign shut_hys = sync2[5];
  assign pin_level = sync2[6];

  // ------------------------------------------------------------
  // register file and bus slave
  // ------------------------------------------------------------
  logic [31:0] config_reg; // modes, report enable, retry count
  logic [31:0] thresh_reg; // closed-loop and open-loop limits
  logic [31:0] timing_reg; // filter cycles and retry ticks
  logic clear_cmd; // one-cycle clear-fault pulse
  logic wr_take; // write takes effect this edge
  logic [31:0] rd_value; // read mux
  logic [7:0] status; // live status bits

  // byte-enable merge
  function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_be

  // write lands where waitrequest is seen low
  assign wr_take = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;

  // one wait state per access: keeps read data registered
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      AVS_WAITREQUEST_OUT <= !((AVS_READ_IN || AVS_WRITE_IN) &&
                               AVS_WAITREQUEST_OUT);
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_value = 32'h0000_0000;
    case (AVS_ADDRESS_IN)
      `FR_REG_CONFIG: rd_value = config_reg;
      `FR_REG_THRESH: rd_value = thresh_reg;
      `FR_REG_TIMING: rd_value = timing_reg;
      `FR_REG_STATUS: rd_value = {24'h00_0000, status};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // read data loaded in the waiting cycle
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else if (AVS_READ_IN && AVS_WAITREQUEST_OUT) begin
      AVS_READDATA_OUT <= rd_value;
    end
  end

  // configuration writes; unmapped writes are dropped
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= `FR_CONFIG_RST;
      thresh_reg <= `FR_THRESH_RST;
      timing_reg <= `FR_TIMING_RST;
    end else if (wr_take) begin
      case (AVS_ADDRESS_IN)
        `FR_REG_CONFIG: config_reg <= merge_be(config_reg,
                          AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        `FR_REG_THRESH: thresh_reg <= merge_be(thresh_reg,
                          AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        `FR_REG_TIMING: timing_reg <= merge_be(timing_reg,
                          AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        default: ;
      endcase
    end
  end

  // clear-fault command: write one, self-clearing
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      clear_cmd <= 1'b0;
    end else begin
      clear_cmd <= wr_take && (AVS_ADDRESS_IN == `FR_REG_CONTROL) &&
                   AVS_BYTEENABLE_IN[0] &&
                   AVS_WRITEDATA_IN[`FR_CTL_CLEAR_BIT]; // see (R19)
    end
  end

  // field views
  logic [3:0] cyc_mode; // cycle-limit response select
  logic [3:0] stall_mode; // stall-current response select
  logic warn_rep; // thermal warning report enable
  logic [3:0] cyc_retry; // cycle-limit retry count
  logic [FILTER_W-1:0] filter_time; // stall filter, clock cycles
  logic [RETRY_W-1:0] retry_time; // stall retry, microsecond ticks

  assign cyc_mode = config_reg[`FR_CFG_CYC_MODE_LSB +: 4];
  assign stall_mode = config_reg[`FR_CFG_STALL_MODE_LSB +: 4];
  assign warn_rep = config_reg[`FR_CFG_WARN_REP_BIT];
  assign cyc_retry = config_reg[`FR_CFG_CYC_RETRY_LSB +: 4];
  assign filter_time = timing_reg[`FR_TIM_FILTER_LSB +: FILTER_W];
  assign retry_time = timing_reg[`FR_TIM_RETRY_LSB +: RETRY_W];

  // ------------------------------------------------------------
  // cycle-by-cycle current limit
  // ------------------------------------------------------------
  fault_resp_pkg::cyc_state_t cyc_state; // response state
  logic [3:0] cyc_held; // mode latched at entry
  logic [3:0] cyc_pwm_count; // PWM starts seen while limiting

  // mode latched on entry so a rewrite mid-event cannot strand us
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      cyc_state <= fault_resp_pkg::CYC_IDLE;
      cyc_held <= 4'h0;
      cyc_pwm_count <= 4'h0;
    end else begin
      case (cyc_state)
        fault_resp_pkg::CYC_IDLE: begin
          cyc_pwm_count <= 4'h0;
          if (trip) begin // see (R1)
            cyc_held <= cyc_mode;
            if (cyc_mode[3:2] == 2'b00 || cyc_mode[3:1] == 3'b010) begin
              cyc_state <= fault_resp_pkg::CYC_LIMIT; // see (R3)
            end else if (cyc_mode == 4'h6) begin
              cyc_state <= fault_resp_pkg::CYC_REPORT; // see (R7)
            end // other codes: nothing, see (R8)
          end
        end
        fault_resp_pkg::CYC_LIMIT: begin
          case (cyc_held[2:1])
            2'b00: begin // next-cycle recovery
              if (PWM_START_IN) begin
                cyc_state <= fault_resp_pkg::CYC_IDLE; // see (R3)
              end
            end
            2'b01: begin // threshold recovery
              if (!trip) begin
                cyc_state <= fault_resp_pkg::CYC_IDLE; // see (R5)
              end
            end
            default: begin // counted recovery, retry+1 starts
              if (PWM_START_IN) begin
                if (cyc_pwm_count == cyc_retry) begin
                  cyc_state <= fault_resp_pkg::CYC_IDLE; // see (R6)
                end else begin
                  cyc_pwm_count <= cyc_pwm_count + 4'h1;
                end
              end
            end
          endcase
        end
        fault_resp_pkg::CYC_REPORT: begin
          // clear counts only with trip gone
          if (clear_cmd && !trip) begin
            cyc_state <= fault_resp_pkg::CYC_IDLE; // see (R7)
          end
        end
        default: cyc_state <= fault_resp_pkg::CYC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // stall current limit
  // ------------------------------------------------------------
  fault_resp_pkg::stall_state_t stall_state; // response state
  logic [1:0] stall_stage_sel; // low mode bits latched at entry
  logic [FILTER_W:0] filt_count; // time above threshold
  logic stall_event; // filter time exceeded
  logic [5:0] tick_div; // microsecond prescaler
  logic tick; // one-cycle microsecond pulse
  logic [RETRY_W-1:0] retry_count; // ticks spent in retry

  // filter restarts when sense drops or a response runs
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      filt_count <= '0;
    end else if (!over ||
                 stall_state != fault_resp_pkg::STALL_IDLE) begin
      filt_count <= '0; // see (R21)
    end else if (!stall_event) begin
      filt_count <= filt_count + 1'b1;
    end
  end

  // strictly longer than the programmed time
  assign stall_event = filt_count > {1'b0, filter_time}; // see (R9)

  // free-running microsecond tick
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      tick_div <= 6'h00;
      tick <= 1'b0;
    end else if (tick_div == 6'(`FR_TICK_CYCLES - 1)) begin
      tick_div <= 6'h00;
      tick <= 1'b1;
    end else begin
      tick_div <= tick_div + 6'h01;
      tick <= 1'b0;
    end
  end

  // stall response; unlisted codes such as 1010 do nothing
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      stall_state <= fault_resp_pkg::STALL_IDLE;
      stall_stage_sel <= 2'b00;
      retry_count <= '0;
    end else begin
      case (stall_state)
        fault_resp_pkg::STALL_IDLE: begin
          retry_count <= '0; // see (R21)
          if (stall_event && !(stall_mode[3] && stall_mode[0])) begin
            stall_stage_sel <= stall_mode[1:0]; // see (R10)
            if (stall_mode[3:2] == 2'b00) begin
              stall_state <= fault_resp_pkg::STALL_LATCH; // see (R11)
            end else if (stall_mode[3:2] == 2'b01) begin
              stall_state <= fault_resp_pkg::STALL_RETRY; // see (R12)
            end else if (stall_mode == 4'h8) begin
              stall_state <= fault_resp_pkg::STALL_REPORT; // see (R13)
            end
          end // 1xx1 filtered out above, see (R14)
        end
        fault_resp_pkg::STALL_LATCH,
        fault_resp_pkg::STALL_REPORT: begin
          if (clear_cmd && !over) begin
            stall_state <= fault_resp_pkg::STALL_IDLE; // see (R11)
          end
        end
        fault_resp_pkg::STALL_RETRY: begin
          if (retry_count >= retry_time) begin
            stall_state <= fault_resp_pkg::STALL_IDLE; // see (R12)
          end else if (tick) begin
            retry_count <= retry_count + 1'b1;
          end
        end
        default: stall_state <= fault_resp_pkg::STALL_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // thermal warning and shutdown
  // ------------------------------------------------------------
  logic warn_active; // warning holding the pin
  logic warn_flag; // sticky warning status
  logic shut_active; // drivers held off
  logic shut_flag; // sticky shutdown status
  logic ot_flag; // sticky overtemperature status
  logic warn_set; // reported warning condition

  assign warn_set = warn_rep && warn;

  // hysteresis on both limits; set beats clear
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      warn_active <= 1'b0;
      warn_flag <= 1'b0;
      shut_active <= 1'b0;
      shut_flag <= 1'b0;
      ot_flag <= 1'b0;
    end else begin
      if (warn_set) begin
        warn_active <= 1'b1; // see (R15)
      end else if (!warn_hys) begin
        warn_active <= 1'b0;
      end
      if (warn_set) begin
        warn_flag <= 1'b1;
      end else if (clear_cmd && !warn_hys) begin
        warn_flag <= 1'b0; // see (R16)
      end
      if (shut) begin
        shut_active <= 1'b1; // see (R17)
      end else if (!shut_hys) begin
        shut_active <= 1'b0;
      end
      if (shut) begin
        shut_flag <= 1'b1; // no enable gate, see (R18)
      end else if (clear_cmd) begin
        shut_flag <= 1'b0;
      end
      if (warn_set || shut) begin
        ot_flag <= 1'b1;
      end else if (clear_cmd && !warn_hys && !shut_active) begin
        ot_flag <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // combined fault view and outputs
  // ------------------------------------------------------------
  logic ctrl_fault; // controller-fault status
  logic pin_low; // fault pin request
  fault_resp_pkg::stage_t stage; // combined stage request

  assign ctrl_fault =
    (cyc_state == fault_resp_pkg::CYC_LIMIT && !cyc_held[0]) ||
    (cyc_state == fault_resp_pkg::CYC_REPORT) ||
    (stall_state != fault_resp_pkg::STALL_IDLE); // see (R4)
  assign pin_low = ctrl_fault || warn_active || shut_active;

  assign status = {pin_level, shut_flag, warn_flag, ot_flag,
                   stall_state != fault_resp_pkg::STALL_IDLE,
                   cyc_state != fault_resp_pkg::CYC_IDLE,
                   shut_active, ctrl_fault};

  // shutdown first, then stall stage, then recirculation
  always_comb begin
    stage = fault_resp_pkg::STAGE_NORMAL;
    if (shut_active) begin
      stage = fault_resp_pkg::STAGE_ALL_OFF; // see (R17)
    end else if (stall_state == fault_resp_pkg::STALL_LATCH ||
                 stall_state == fault_resp_pkg::STALL_RETRY) begin
      case (stall_stage_sel) // see (R10)
        2'b00: stage = fault_resp_pkg::STAGE_ALL_OFF;
        2'b01: stage = fault_resp_pkg::STAGE_SWITCH_OFF;
        2'b10: stage = fault_resp_pkg::STAGE_HIGH_ON;
        default: stage = fault_resp_pkg::STAGE_LOW_ON;
      endcase
    end else if (cyc_state == fault_resp_pkg::CYC_LIMIT) begin
      stage = fault_resp_pkg::STAGE_RECIRC; // see (R3)
    end
  end

  // registered outputs; pin only pulled low
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      FAULT_PIN_N_OUT <= 1'b0;
      FAULT_PIN_N_OE_OUT <= 1'b0;
      GATE_STAGE_OUT <= 3'h0;
      CHARGE_PUMP_EN_OUT <= 1'b0;
      CYC_THRESHOLD_OUT <= 8'h00;
    end else begin
      FAULT_PIN_N_OUT <= 1'b0;
      FAULT_PIN_N_OE_OUT <= pin_low;
      GATE_STAGE_OUT <= stage;
      CHARGE_PUMP_EN_OUT <= !shut_active; // see (R17)
      CYC_THRESHOLD_OUT <= LOOP_CLOSED_IN ?
        thresh_reg[`FR_THR_CLOSED_LSB +: 8] :
        thresh_reg[`FR_THR_OPEN_LSB +: 8]; // see (R2)
    end
  end

endmodule : fault_resp

// ---- fault_resp_monitor.sv ----
`timescale 1ns/100ps
`include "fault_resp_consts.svh"
module fault_resp_monitor (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // bus
  input wire logic [`FR_ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic AVS_WAITREQUEST_OUT,
  // indications
  input wire logic CYC_TRIP_IN,
  input wire logic STALL_OVER_IN,
  input wire logic TEMP_WARN_IN,
  input wire logic TEMP_SHUT_IN,
  // outputs watched
  input wire logic FAULT_PIN_N_OE_OUT,
  input wire logic [2:0] GATE_STAGE_OUT,
  input wire logic CHARGE_PUMP_EN_OUT
);
  // ------
  // helpers
  // ------
  logic [31:0] cfg; // shadow of config, full byte enables assumed
  logic [7:0] so_sh; // recent stall input history
  logic [3:0] clr_sh; // recent clear writes
  logic bus_wr; // write accepted this edge
  assign bus_wr = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
  // config shadow
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) cfg <= 32'h0;
    else if (bus_wr && AVS_ADDRESS_IN == `FR_REG_CONFIG)
      cfg <= AVS_WRITEDATA_IN;
  end
  // stall history: filter met before any stage
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) so_sh <= 8'h0;
    else so_sh <= {so_sh[6:0], STALL_OVER_IN};
  end
  // clear history, latched stage may only drop after one
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) clr_sh <= 4'h0;
    else clr_sh <= {clr_sh[2:0], bus_wr && AVS_WRITEDATA_IN[0] &&
      AVS_ADDRESS_IN == `FR_REG_CONTROL};
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  property p_cyc_enter;
    (cfg[3:0] < 4'h6 && CYC_TRIP_IN) [*6] |->
      GATE_STAGE_OUT == fault_resp_pkg::STAGE_RECIRC &&
      FAULT_PIN_N_OE_OUT == !cfg[0];
  endproperty
  a_cyc_enter: assert property (p_cyc_enter)
    else $error("cycle limit entry wrong");
  property p_cyc_thr_exit;
    (cfg[3:1] == 3'h1 && !CYC_TRIP_IN) [*6] |->
      GATE_STAGE_OUT != fault_resp_pkg::STAGE_RECIRC && !FAULT_PIN_N_OE_OUT;
  endproperty
  a_cyc_thr_exit: assert property (p_cyc_thr_exit)
    else $error("threshold recovery missing");
  property p_cyc_report;
    (cfg[3:0] == 4'h6 && CYC_TRIP_IN) [*6] |->
      FAULT_PIN_N_OE_OUT && GATE_STAGE_OUT == fault_resp_pkg::STAGE_NORMAL;
  endproperty
  a_cyc_report: assert property (p_cyc_report)
    else $error("cycle report mode wrong");
  property p_cyc_off;
    ((cfg[3] || cfg[3:0] == 4'h7) && CYC_TRIP_IN) [*6] |->
      GATE_STAGE_OUT != fault_resp_pkg::STAGE_RECIRC && !FAULT_PIN_N_OE_OUT;
  endproperty
  a_cyc_off: assert property (p_cyc_off)
    else $error("disabled cycle limit acted");
  property p_stall_filter;
    $rose(GATE_STAGE_OUT inside {[3'h2:3'h5]}) && !cfg[7] |->
      so_sh[7:4] == 4'hF;
  endproperty
  a_stall_filter: assert property (p_stall_filter)
    else $error("stall stage without filter time");
  property p_stall_latch;
    cfg[7:6] == 2'h0 && GATE_STAGE_OUT inside {[3'h2:3'h5]} &&
      clr_sh == 4'h0 |=> $stable(GATE_STAGE_OUT);
  endproperty
  a_stall_latch: assert property (p_stall_latch)
    else $error("latched stage left without clear");
  property p_stall_quiet;
    cfg[7:4] == 4'h8 || (cfg[7] && cfg[4]) |-> GATE_STAGE_OUT < 3'h2;
  endproperty
  a_stall_quiet: assert property (p_stall_quiet)
    else $error("stall stage in passive mode");
  property p_warn;
    (cfg[8] && TEMP_WARN_IN) [*6] |-> FAULT_PIN_N_OE_OUT;
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning not on pin");
  property p_shut;
    TEMP_SHUT_IN [*6] |-> !CHARGE_PUMP_EN_OUT && FAULT_PIN_N_OE_OUT &&
      GATE_STAGE_OUT == fault_resp_pkg::STAGE_ALL_OFF;
  endproperty
  a_shut: assert property (p_shut)
    else $error("shutdown response wrong");
  // main scenarios reached
  c_recirc: cover property (GATE_STAGE_OUT == fault_resp_pkg::STAGE_RECIRC);
  c_low_on: cover property (GATE_STAGE_OUT == fault_resp_pkg::STAGE_LOW_ON);
  c_pump_off: cover property (!CHARGE_PUMP_EN_OUT);
endmodule : fault_resp_monitor

// ---- fault_pin_model.sv ----
`timescale 1ns/100ps
// open-drain fault line as the host sees it
module fault_pin_model (
  // device side
  input wire logic oe_in,
  input wire logic drv_in,
  // host side
  output logic pin_out
);
  // pull-up wins whenever nobody sinks the line
  assign pin_out = oe_in ? drv_in : 1'b1;
endmodule : fault_pin_model

// ---- tb.sv ----
`timescale 1ns/100ps
`include "fault_resp_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
$display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb;
  // ------
  // signals
  // ------
  logic clk;
  logic rst_n = 0, rd_en = 0, wr_en = 0, trip = 0, stall = 0, pwm = 0;
  logic tw = 0, twh = 0, ts = 0, tsh = 0, loop_c = 0;
  logic wait_r, pin, oe, drv, pump, e;
  logic [`FR_ADDR_W-1:0] adr = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic [2:0] stage, es;
  logic [7:0] thr;
  int n_errors = 0, n_checks = 0;
  // flag expected per mode after each step
  logic [15:0] ch [5] = '{16'h007F, 16'h0073, 16'h0070, 16'h0040, 16'h0};
  logic [15:0] sh [5] = '{16'h0, 16'h01FF, 16'h01FF, 16'h010F, 16'h0};
  localparam logic [15:0] REP = 16'h0055; // reporting cycle modes
  localparam logic [15:0] RC = 16'h003F; // recirculating cycle modes
  fault_resp u_fault_resp (.CLK_IN(clk), .RST_N_IN(rst_n),
    .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd_en), .AVS_WRITE_IN(wr_en),
    .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(4'hF),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wait_r),
    .CYC_TRIP_IN(trip), .STALL_OVER_IN(stall), .TEMP_WARN_IN(tw),
    .TEMP_WARN_HYS_IN(twh), .TEMP_SHUT_IN(ts), .TEMP_SHUT_HYS_IN(tsh),
    .PWM_START_IN(pwm), .LOOP_CLOSED_IN(loop_c), .FAULT_PIN_N_IN(pin),
    .FAULT_PIN_N_OUT(drv), .FAULT_PIN_N_OE_OUT(oe),
    .GATE_STAGE_OUT(stage), .CHARGE_PUMP_EN_OUT(pump),
    .CYC_THRESHOLD_OUT(thr));
  fault_pin_model u_fault_pin_model (.oe_in(oe), .drv_in(drv),
    .pin_out(pin));
  // ------
  // tasks
  // ------
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // one access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [`FR_ADDR_W-1:0] a,
      input logic [31:0] d);
    int n = 0;
    adr <= a;
    wdat <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk);
    while (wait_r !== 1'b0 && n < 40) begin
      n++;
      @(posedge clk);
    end
    q = rdat;
    if (n >= 40) n_errors++;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic st(input int n);
    wt(n);
    bus(1'b0, `FR_REG_STATUS, 32'h0);
  endtask : st
  task automatic clr();
    bus(1'b1, `FR_REG_CONTROL, 32'h1);
  endtask : clr
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // ------
  // clock, watchdog
  // ------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // whole run is a few thousand cycles
  initial begin
    wt(30000);
    n_errors++;
    summarize();
  end
  // ------
  // tests
  // ------
  initial begin
    wt(10);
    rst_n <= 1'b1;
    wt(4);
    // reset values, unmapped, read-only
    bus(1'b0, `FR_REG_CONFIG, 32'h0);
    `CHK(q, `FR_CONFIG_RST)
    bus(1'b0, `FR_REG_THRESH, 32'h0);
    `CHK(q, `FR_THRESH_RST)
    bus(1'b0, `FR_REG_TIMING, 32'h0);
    `CHK(q, `FR_TIMING_RST)
    bus(1'b0, 5'h14, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, `FR_REG_STATUS, 32'hFF);
    st(0);
    `CHK(q, 32'h80)
    `CHK(pump, 1'b1)
    // threshold follows loop state
    bus(1'b1, `FR_REG_THRESH, 32'h1234);
    loop_c <= 1'b1;
    wt(4);
    `CHK(thr, 8'h34)
    loop_c <= 1'b0;
    wt(4);
    `CHK(thr, 8'h12)
    bus(1'b1, `FR_REG_TIMING, 32'h0002_0004);
    // cycle limit: trip, trip gone, two pwm starts, clear
    for (int m = 0; m < 16; m++) begin
      bus(1'b1, `FR_REG_CONFIG, 32'h1000 | 32'(m));
      for (int k = 0; k < 5; k++) begin
        trip <= (k == 0);
        pwm <= (k == 2 || k == 3);
        if (k == 4) clr();
        @(posedge clk);
        pwm <= 1'b0;
        e = ch[k][m];
        st(8);
        `CHK(q[2], e)
        `CHK(oe, e & REP[m])
        `CHK(q[7], !(e & REP[m]))
        `CHK(stage, {2'b0, e & RC[m]})
        if (k == 0) `CHK(q[0], e & REP[m])
        if (k == 4) `CHK(q[7:0], 8'h80)
      end
    end
    // stall: glitch, hold, drop, retry span, clear
    for (int m = 0; m < 16; m++) begin
      bus(1'b1, `FR_REG_CONFIG, 32'(m) << 4);
      for (int k = 0; k < 5; k++) begin
        if (k == 0) begin
          stall <= 1'b1;
          wt(3);
        end
        stall <= (k == 1);
        if (k == 4) clr();
        e = sh[k][m];
        es = (e && m < 8) ? 3'(2 + m % 4) : 3'h0;
        st(k == 1 ? 14 : (k == 3 ? 100 : 8));
        `CHK(q[3], e)
        `CHK(q[0], e)
        `CHK(oe, e)
        `CHK(stage, es)
      end
    end
    // warning: off, on, between limits, cool, clear
    bus(1'b1, `FR_REG_CONFIG, 32'h0A0);
    tw <= 1'b1;
    twh <= 1'b1;
    wt(8);
    `CHK(oe, 1'b0)
    bus(1'b1, `FR_REG_CONFIG, 32'h1A0);
    st(8);
    `CHK({oe, q[5:4], stage}, 6'h38)
    tw <= 1'b0;
    wt(8);
    `CHK(oe, 1'b1)
    twh <= 1'b0;
    st(8);
    `CHK({oe, q[5]}, 2'h1)
    clr();
    st(8);
    `CHK(q[5:4], 2'h0)
    // shutdown: on, between limits, cool, clear
    ts <= 1'b1;
    tsh <= 1'b1;
    st(8);
    `CHK({stage, pump, oe, q[6], q[4], q[1]}, 8'h4F)
    ts <= 1'b0;
    wt(8);
    `CHK({stage, pump}, 4'h4)
    tsh <= 1'b0;
    st(8);
    `CHK({stage, pump, oe, q[6], q[1]}, 7'h0A)
    clr();
    st(8);
    `CHK(q, 32'h80)
    summarize();
  end
endmodule : tb
bind fault_resp fault_resp_monitor u_fault_resp_monitor (.*);
